/* shared/vic_pkg.sv */
// constants, types and layouts shared by the vector-fetch controller
package vic_pkg;
  // device side: exception entry and vector load
  localparam logic [31:0] IRQ_EXC_VECTOR  = 32'h0000_0018;
  localparam logic [31:0] PC_PREFETCH     = 32'h0000_0008;
  localparam logic [31:0] LOAD_NEG_OFFSET = 32'h0000_0ff0;
  localparam logic [31:0] VECT_ADDR_REG   = IRQ_EXC_VECTOR + PC_PREFETCH - LOAD_NEG_OFFSET;
  localparam logic [31:0] DEF_VECT_REG    = 32'hffff_f034;
  localparam logic [31:0] FIQ_STATUS_REG  = 32'hffff_f004;
  localparam logic [31:0] SLOT_ADDR_BASE  = 32'hffff_f100;
  localparam logic [31:0] SLOT_CTRL_BASE  = 32'hffff_f200;
  // controller's own register offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_ADDR    = 8'h04;
  localparam logic [7:0]  OFS_WDATA   = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0c;
  localparam logic [7:0]  OFS_VECTOR  = 8'h10;
  localparam logic [7:0]  OFS_RDATA   = 8'h14;
  // control bit positions
  localparam int          CTRL_GO     = 0;
  localparam int          CTRL_WRITE  = 1;
  localparam int          CTRL_PULSE  = 2;
  localparam int          CTRL_EOI    = 3;
  localparam int          CTRL_AUTO   = 4;
  // status bit positions
  localparam int          STS_BUSY    = 0;
  localparam int          STS_IRQ     = 1;
  localparam int          STS_FIQ     = 2;
  localparam int          STS_VALID   = 3;
  localparam int          STS_AUTO    = 4;
  // bus encodings and reset values
  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } vic_mreq_t;

  typedef enum logic [1:0] {
    VIC_IDLE,
    VIC_ADDR,
    VIC_DATA
  } vic_state_t;
endpackage : vic_pkg

/* logic/vic_host.sv */
// controller that fetches vectors from and services the interrupt controller
// Operation
// [R01] stale request yields default vector on fetch
// [R02] software installs a checked default handler
// [R03] core takes irq latched while disabling
// [R04] irq return restores status, fiq stays off
// [R05] peripheral clear propagates to status views
// [R06] vector register write releases priority hardware
// [R07] write vector register before returning
// [R08] enable-clear one disables that source
// [R09] soft-clear one clears only that bit
// [R10] clear acts once; write zero before reuse
// [R11] uncleared watchdog: disable via enable-clear
// [R12] vectored slot 0 hit returns slot address
// [R13] non-vectored only returns default vector
// [R14] slot control 0x26/0x2a select sources 6/10
// [R15] select zero classifies source as irq
// [R16] enable register bit per channel index
// [R17] irq entry loads pc from vector register
// [R18] negative pc-relative load hits vector register
// [R19] several fiq sources: read fiq status
// [R20] remap vectors before enabling interrupts
// [R21] sixteen fixed-priority slots, source and enable
// [R22] duplicate source uses lower slot
// [R23] vector register writes never alter reads
// [R24] irq/fiq outputs follow enabled classified sources
// [R25] raw state is line or soft bit
module vic_host (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // ahb-lite slave, own registers
  input  wire logic              s_hsel_i,
  input  wire logic [31:0]       s_haddr_i,
  input  wire logic [1:0]        s_htrans_i,
  input  wire logic              s_hwrite_i,
  input  wire logic [2:0]        s_hsize_i,
  input  wire logic [31:0]       s_hwdata_i,
  input  wire logic              s_hready_i,
  output logic [31:0]            s_hrdata_o,
  output logic                   s_hreadyout_o,
  output logic                   s_hresp_o,
  // ahb-lite master toward the interrupt controller
  output vic_pkg::vic_mreq_t     m_req_o,
  input  wire logic [31:0]       m_hrdata_i,
  input  wire logic              m_hready_i,
  // interrupt lines from the interrupt controller
  input  wire logic              irq_i,
  input  wire logic              fiq_i
);
  import vic_pkg::*;

  vic_state_t  state_reg;
  vic_state_t  state_next;
  vic_mreq_t   mreq_reg;
  logic        irq_meta_reg;
  logic        irq_sync_reg;
  logic        fiq_meta_reg;
  logic        fiq_sync_reg;
  logic        s_act_reg;
  logic        s_wr_reg;
  logic [7:0]  s_ofs_reg;
  logic [31:0] s_hrdata_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] vector_reg;
  logic [31:0] rdata_reg;
  logic        auto_reg;
  logic        valid_reg;
  logic        pend_reg;
  logic [31:0] p_addr_reg;
  logic [31:0] p_data_reg;
  logic        p_wr_reg;
  logic        p_pulse_reg;
  logic [31:0] cur_data_reg;
  logic        zero_pend_reg;
  logic        vec_op_reg;

  // slave decode
  wire         s_sel      = s_hsel_i && s_hready_i && s_htrans_i[1];
  wire         s_wr_data  = s_act_reg && s_wr_reg;
  wire         wr_ctrl    = s_wr_data && (s_ofs_reg == OFS_CTRL);
  wire         wr_addr    = s_wr_data && (s_ofs_reg == OFS_ADDR);
  wire         wr_wdata   = s_wr_data && (s_ofs_reg == OFS_WDATA);
  wire         busy       = pend_reg || (state_reg != VIC_IDLE);
  wire         take_go    = wr_ctrl && !busy && s_hwdata_i[CTRL_GO];
  wire         take_eoi   = wr_ctrl && !busy && !s_hwdata_i[CTRL_GO] && s_hwdata_i[CTRL_EOI];
  wire         take_cmd   = take_go || take_eoi;
  wire [31:0]  status_w   = {27'h000_0000, auto_reg, valid_reg, fiq_sync_reg,
                             irq_sync_reg, busy}; // R19
  wire [31:0]  s_rmux     = (s_haddr_i[7:0] == OFS_CTRL)   ? {27'h000_0000, auto_reg, 4'h0} :
                            (s_haddr_i[7:0] == OFS_ADDR)   ? addr_reg :
                            (s_haddr_i[7:0] == OFS_WDATA)  ? wdata_reg :
                            (s_haddr_i[7:0] == OFS_STATUS) ? status_w :
                            (s_haddr_i[7:0] == OFS_VECTOR) ? vector_reg :
                            (s_haddr_i[7:0] == OFS_RDATA)  ? rdata_reg : RST_WORD;

  // master sequencing
  wire         launch_cmd = (state_reg == VIC_IDLE) && pend_reg;
  wire         launch_vec = (state_reg == VIC_IDLE) && !pend_reg && auto_reg &&
                            irq_sync_reg && !valid_reg; // R03 R24
  wire         addr_done  = (state_reg == VIC_ADDR) && m_hready_i;
  wire         data_done  = (state_reg == VIC_DATA) && m_hready_i;
  wire         second     = data_done && zero_pend_reg;
  wire         vec_done   = data_done && vec_op_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      VIC_IDLE: begin
        if (launch_cmd || launch_vec) begin
          state_next = VIC_ADDR;
        end
      end
      VIC_ADDR: begin
        if (m_hready_i) begin
          state_next = VIC_DATA;
        end
      end
      VIC_DATA: begin
        if (m_hready_i) begin
          state_next = second ? VIC_ADDR : VIC_IDLE;
        end
      end
      default: begin
        state_next = VIC_IDLE;
      end
    endcase
  end

  // input synchronisers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
      fiq_meta_reg <= 1'b0;
      fiq_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_i;
      irq_sync_reg <= irq_meta_reg;
      fiq_meta_reg <= fiq_i;
      fiq_sync_reg <= fiq_meta_reg;
    end
  end

  // slave address phase and read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_act_reg     <= 1'b0;
      s_wr_reg      <= 1'b0;
      s_ofs_reg     <= 8'h00;
      s_hrdata_reg  <= RST_WORD;
      s_hreadyout_o <= 1'b1;
      s_hresp_o     <= 1'b0;
    end else begin
      s_act_reg     <= s_sel;
      s_wr_reg      <= s_hwrite_i;
      s_ofs_reg     <= s_haddr_i[7:0];
      s_hreadyout_o <= 1'b1;
      s_hresp_o     <= 1'b0;
      if (s_sel && !s_hwrite_i) begin
        s_hrdata_reg <= s_rmux;
      end
    end
  end

  assign s_hrdata_o = s_hrdata_reg;

  // own writable registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_reg  <= RST_WORD;
      wdata_reg <= RST_WORD;
      auto_reg  <= 1'b0;
    end else begin
      if (wr_addr) begin
        addr_reg <= s_hwdata_i;
      end
      if (wr_wdata) begin
        wdata_reg <= s_hwdata_i;
      end
      if (wr_ctrl) begin
        auto_reg <= s_hwdata_i[CTRL_AUTO]; // R04 R20
      end
    end
  end

  // command capture; end of interrupt writes the vector register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg    <= 1'b0;
      p_addr_reg  <= RST_WORD;
      p_data_reg  <= RST_WORD;
      p_wr_reg    <= 1'b0;
      p_pulse_reg <= 1'b0;
    end else if (take_cmd) begin
      pend_reg    <= 1'b1;
      p_addr_reg  <= take_eoi ? VECT_ADDR_REG : addr_reg; // R06 R07 R11
      p_data_reg  <= wdata_reg; // R23
      p_wr_reg    <= take_eoi || s_hwdata_i[CTRL_WRITE];
      p_pulse_reg <= take_go && s_hwdata_i[CTRL_PULSE];
    end else if (launch_cmd) begin
      pend_reg <= 1'b0;
    end
  end

  // bus state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= VIC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // master request signals
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mreq_reg      <= '{haddr: RST_WORD, htrans: HTRANS_IDLE, hwrite: 1'b0,
                         hsize: HSIZE_WORD, hwdata: RST_WORD};
      cur_data_reg  <= RST_WORD;
      zero_pend_reg <= 1'b0;
      vec_op_reg    <= 1'b0;
    end else if (launch_cmd) begin
      mreq_reg.haddr  <= p_addr_reg;
      mreq_reg.htrans <= HTRANS_NONSEQ;
      mreq_reg.hwrite <= p_wr_reg;
      cur_data_reg    <= p_data_reg;
      zero_pend_reg   <= p_pulse_reg && p_wr_reg;
      vec_op_reg      <= 1'b0;
    end else if (launch_vec) begin
      mreq_reg.haddr  <= VECT_ADDR_REG; // R17 R18
      mreq_reg.htrans <= HTRANS_NONSEQ;
      mreq_reg.hwrite <= 1'b0;
      zero_pend_reg   <= 1'b0;
      vec_op_reg      <= 1'b1;
    end else if (addr_done) begin
      mreq_reg.htrans <= HTRANS_IDLE;
      mreq_reg.hwdata <= cur_data_reg;
    end else if (second) begin
      mreq_reg.htrans <= HTRANS_NONSEQ; // R10
      cur_data_reg    <= RST_WORD; // R10
      zero_pend_reg   <= 1'b0;
    end
  end

  assign m_req_o = mreq_reg;

  // fetched vector and read-back data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vector_reg <= RST_WORD;
      rdata_reg  <= RST_WORD;
      valid_reg  <= 1'b0;
    end else begin
      if (data_done && !mreq_reg.hwrite) begin
        rdata_reg <= m_hrdata_i;
      end
      if (vec_done) begin
        vector_reg <= m_hrdata_i; // R01 R02 R12 R13
        valid_reg  <= 1'b1;
      end else if (take_eoi) begin
        valid_reg  <= 1'b0;
      end
    end
  end
endmodule : vic_host

/* tb/vic_dev_model.sv */
// behavioural model of the interrupt controller behind the host
module vic_dev_model #(
  parameter logic [31:0] RAW_R = 32'hffff_f008,
  parameter logic [31:0] SEL_R = 32'hffff_f00c,
  parameter logic [31:0] EN_R  = 32'hffff_f010,
  parameter logic [31:0] ENC_R = 32'hffff_f014,
  parameter logic [31:0] SW_R  = 32'hffff_f018,
  parameter logic [31:0] SWC_R = 32'hffff_f01c
) (
  // clock, reset, wait-state request
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               slow_i,
  // bus from host, peripheral lines
  input  wire vic_pkg::vic_mreq_t req_i,
  input  wire logic [31:0]        src_i,
  // bus answer, interrupt lines
  output logic [31:0]             hrdata_o,
  output logic                    hready_o,
  output logic                    irq_o,
  output logic                    fiq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import vic_pkg::*;
  logic [31:0] sel, en, sw, dv, raw, act, rd, vec, ad, wd;
  logic [31:0] va [16];
  logic [5:0]  vc [16];
  logic        dph, wr, tog;
  assign wd       = req_i.hwdata;
  assign raw      = src_i | sw;
  assign act      = raw & en;
  assign irq_o    = |(act & ~sel);
  assign fiq_o    = |(act & sel);
  assign hready_o = !slow_i || tog;
  assign hrdata_o = (dph && !wr) ? rd : ~rd;
  always_comb begin
    vec = dv;
    for (int i = 15; i >= 0; i--)
      if (vc[i][5] && act[vc[i][4:0]] && !sel[vc[i][4:0]]) vec = va[i];
  end
  always_comb
    case (ad)
      VECT_ADDR_REG:  rd = vec;
      DEF_VECT_REG:   rd = dv;
      FIQ_STATUS_REG: rd = act & sel;
      RAW_R:          rd = raw;
      SEL_R:          rd = sel;
      EN_R:           rd = en;
      SW_R:           rd = sw;
      default:        rd = ad[9] ? {26'h0, vc[ad[5:2]]} : va[ad[5:2]];
    endcase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {dph, wr, tog, ad, sel, en, sw, dv} <= '0;
      for (int i = 0; i < 16; i++) begin
        va[i] <= '0;
        vc[i] <= '0;
      end
    end else begin
      tog <= !tog;
      if (hready_o) begin
        dph <= req_i.htrans == HTRANS_NONSEQ;
        ad  <= req_i.haddr;
        wr  <= req_i.hwrite;
      end
      if (dph && wr && hready_o)
        case (ad)
          SEL_R:         sel <= wd;
          EN_R:          en <= en | wd;
          ENC_R:         en <= en & ~wd;
          SW_R:          sw <= sw | wd;
          SWC_R:         sw <= sw & ~wd;
          DEF_VECT_REG:  dv <= wd;
          VECT_ADDR_REG: ;
          default:       if (ad[9]) vc[ad[5:2]] <= wd[5:0]; else va[ad[5:2]] <= wd;
        endcase
    end
  end
endmodule : vic_dev_model

/* tb/vic_host_monitor.sv */
// concurrent checks on the host controller's ports
module vic_host_monitor (
  // clock and reset
  input wire logic               clk_i,
  input wire logic               rst_i,
  // slave bus
  input wire logic               s_hsel_i,
  input wire logic               s_hwrite_i,
  input wire logic               s_hready_i,
  input wire logic [31:0]        s_haddr_i,
  input wire logic [31:0]        s_hwdata_i,
  input wire logic [31:0]        s_hrdata_o,
  input wire logic [1:0]         s_htrans_i,
  input wire logic [2:0]         s_hsize_i,
  input wire logic               s_hreadyout_o,
  input wire logic               s_hresp_o,
  // master bus and interrupt lines
  input wire logic [31:0]        m_hrdata_i,
  input wire logic               m_hready_i,
  input wire logic               irq_i,
  input wire logic               fiq_i,
  input wire vic_pkg::vic_mreq_t m_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import vic_pkg::*;
  logic dph, ns;
  assign ns = m_req_o.htrans == HTRANS_NONSEQ;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) dph <= 1'h0;
    else if (m_hready_i) dph <= ns;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_slave_ready: assert property (s_hreadyout_o)
    else $error("slave inserted a wait state");
  chk_slave_okay: assert property (!s_hresp_o)
    else $error("slave response not okay");
  chk_addr_held: assert property (ns && !m_hready_i |=> ns && $stable(m_req_o.haddr))
    else $error("address phase dropped before ready");
  chk_idle_after: assert property (ns && m_hready_i |=> m_req_o.htrans == HTRANS_IDLE)
    else $error("no idle in data phase");
  chk_wdata_held: assert property (dph && !m_hready_i |=> $stable(m_req_o.hwdata))
    else $error("write data changed before ready");
  chk_word_size: assert property (ns |-> m_req_o.hsize == HSIZE_WORD)
    else $error("transfer size not word");
  chk_rdata_kept: assert property
    (!(s_hsel_i && s_hready_i && s_htrans_i[1] && !s_hwrite_i) |=> $stable(s_hrdata_o))
    else $error("read data changed without read");
  chk_pulse_zero: assert property (dph && m_req_o.hwrite && m_hready_i ##1
    ns && m_req_o.hwrite && m_hready_i |=> m_req_o.hwdata == RST_WORD)
    else $error("second write of pulse not zero");
  cover property (ns && m_req_o.hwrite && m_hready_i);
  cover property (dph && !m_hready_i);
  cover property (ns && !m_req_o.hwrite && m_req_o.haddr == VECT_ADDR_REG);
endmodule : vic_host_monitor

/* tb/vic_host_tb_top.sv */
// self-checking bench for the host controller
module vic_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vic_pkg::*;
  localparam logic [31:0] DEFV = 32'h0000_1000, AV0 = 32'h0000_2000, AV1 = 32'h0000_3000;
  localparam logic [31:0] RAWS = 32'hffff_f008, SELR = 32'hffff_f00c, ENR = 32'hffff_f010;
  localparam logic [31:0] ENC  = 32'hffff_f014, SWR = 32'hffff_f018, SWC = 32'hffff_f01c;
  logic        clk_i = 0, rst_i = 1, s_hsel_i = 0, s_hwrite_i = 0, slow = 0;
  logic [31:0] s_haddr_i = 0, s_hwdata_i = 0, src = 0, s_hrdata_o, m_hrdata_i, r;
  logic [1:0]  s_htrans_i = HTRANS_IDLE;
  logic [2:0]  s_hsize_i = HSIZE_WORD;
  logic        s_hreadyout_o, s_hresp_o, m_hready_i, irq_i, fiq_i;
  vic_mreq_t   m_req_o;
  int          bad_count = 0, checked = 0;
  logic [31:0] ms [3] = '{32'h0000_0200, 32'h0000_0600, 32'h0000_0640};
  logic [31:0] ev [3] = '{DEFV, AV1, AV0};
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
  always #12.5 clk_i = ~clk_i;
  vic_host vic_host_i (.clk_i, .rst_i, .s_hsel_i, .s_haddr_i, .s_htrans_i, .s_hwrite_i,
    .s_hsize_i, .s_hwdata_i, .s_hready_i(s_hreadyout_o), .s_hrdata_o, .s_hreadyout_o,
    .s_hresp_o, .m_req_o, .m_hrdata_i, .m_hready_i, .irq_i, .fiq_i);
  vic_dev_model vic_dev_model_i (.clk_i, .rst_i, .slow_i(slow), .req_i(m_req_o),
    .src_i(src), .hrdata_o(m_hrdata_i), .hready_o(m_hready_i), .irq_o(irq_i), .fiq_o(fiq_i));
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!s_hreadyout_o && n < 50);
    if (!s_hreadyout_o) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wt
  task ahb(input logic w, input logic [7:0] o, input logic [31:0] d, output logic [31:0] q);
    s_hsel_i   <= 1;
    s_htrans_i <= HTRANS_NONSEQ;
    s_haddr_i  <= {24'h0, o};
    s_hwrite_i <= w;
    wt();
    s_htrans_i <= HTRANS_IDLE;
    s_hsel_i   <= 0;
    s_hwdata_i <= d;
    wt();
    q = s_hrdata_o;
  endtask : ahb
  task poll(input int b, input logic v);
    int n;
    logic [31:0] q;
    for (n = 0; n < 300; n++) begin
      ahb(0, OFS_STATUS, 0, q);
      if (q[b] === v) break;
    end
    if (n >= 300) begin
      bad_count++;
      report_and_stop();
    end
  endtask : poll
  task dev(input logic w, p, input logic [31:0] a, d, output logic [31:0] q);
    logic [31:0] c;
    c = 32'h1 << CTRL_GO | {31'h0, w} << CTRL_WRITE | {31'h0, p} << CTRL_PULSE;
    ahb(1, OFS_ADDR, a, q);
    ahb(1, OFS_WDATA, d, q);
    ahb(1, OFS_CTRL, c, q);
    poll(STS_BUSY, 0);
    ahb(0, OFS_RDATA, 0, q);
  endtask : dev
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    ahb(1, 8'h18, 32'hffff_ffff, r);
    ahb(0, 8'h18, 0, r);
    `CHK("unmapped", 32'h0, r)
    ahb(0, OFS_STATUS, 0, r);
    `CHK("status", 32'h0, r)
    dev(1, 0, SELR, 0, r);
    dev(1, 0, ENR, 32'h0000_06c0, r);
    dev(1, 0, DEF_VECT_REG, DEFV, r);
    dev(1, 0, SLOT_ADDR_BASE, AV0, r);
    dev(1, 0, SLOT_ADDR_BASE + 32'h4, AV1, r);
    dev(1, 0, SLOT_CTRL_BASE, 32'h0000_0026, r);
    dev(1, 0, SLOT_CTRL_BASE + 32'h4, 32'h0000_002a, r);
    dev(0, 0, ENR, 0, r);
    `CHK("enable", 32'h0000_06c0, r)
    slow <= 1;
    for (int i = 0; i < 3; i++) begin
      src <= ms[i];
      repeat (4) @(posedge clk_i);
      ahb(0, OFS_STATUS, 0, r);
      `CHK("irq", 1'h1, r[STS_IRQ])
      dev(0, 0, VECT_ADDR_REG, 0, r);
      `CHK("vector", ev[i], r)
    end
    slow <= 0;
    ahb(1, OFS_CTRL, 32'h1 << CTRL_AUTO, r);
    poll(STS_VALID, 1);
    ahb(0, OFS_VECTOR, 0, r);
    `CHK("fetch", AV0, r)
    poll(STS_BUSY, 0);
    ahb(1, OFS_CTRL, 32'h1 << CTRL_AUTO | 32'h1 << CTRL_EOI, r);
    poll(STS_BUSY, 0);
    poll(STS_VALID, 1);
    ahb(0, OFS_VECTOR, 0, r);
    `CHK("refetch", AV0, r)
    ahb(1, OFS_CTRL, 32'h0, r);
    poll(STS_BUSY, 0);
    dev(1, 1, ENC, 32'h0000_0040, r);
    dev(0, 0, ENR, 0, r);
    `CHK("enclr", 32'h0000_0680, r)
    src <= 32'h0000_0040;
    dev(0, 0, VECT_ADDR_REG, 0, r);
    `CHK("stale", DEFV, r)
    ahb(0, OFS_STATUS, 0, r);
    `CHK("irq off", 1'h0, r[STS_IRQ])
    // command while busy is refused; a stray set of bit 3 would spoil the soft check
    ahb(1, OFS_ADDR, SWR, r);
    ahb(1, OFS_WDATA, 32'h0000_0008, r);
    ahb(1, OFS_CTRL, 32'h1 << CTRL_GO, r);
    ahb(1, OFS_CTRL, 32'h1 << CTRL_GO | 32'h1 << CTRL_WRITE, r);
    poll(STS_BUSY, 0);
    ahb(0, OFS_RDATA, 0, r);
    `CHK("busy read", 32'h0, r)
    dev(1, 0, SWR, 32'h0000_0005, r);
    dev(1, 1, SWC, 32'h0000_0001, r);
    dev(0, 0, SWR, 0, r);
    `CHK("soft", 32'h0000_0004, r)
    dev(0, 0, RAWS, 0, r);
    `CHK("raw", 32'h0000_0044, r)
    dev(1, 0, SELR, 32'h0000_0200, r);
    src <= 32'h0000_0200;
    dev(0, 0, FIQ_STATUS_REG, 0, r);
    `CHK("fiq status", 32'h0000_0200, r)
    ahb(0, OFS_STATUS, 0, r);
    `CHK("fiq", 1'h1, r[STS_FIQ])
    src <= 0;
    dev(1, 1, SWC, 32'h0000_0004, r);
    dev(0, 0, RAWS, 0, r);
    `CHK("raw clear", 32'h0, r)
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule : vic_host_tb_top
bind vic_host vic_host_monitor vic_host_monitor_i (.clk_i, .rst_i, .s_hsel_i, .s_hwrite_i,
  .s_hready_i, .s_haddr_i, .s_hwdata_i, .s_hrdata_o, .m_hrdata_i, .s_htrans_i, .s_hsize_i,
  .s_hreadyout_o, .s_hresp_o, .m_hready_i, .irq_i, .fiq_i, .m_req_o);
